// [logic/seq_ext_config_regs.sv]
// Purpose: extended sequencer configuration bank behind the index/data port
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes:   all outputs are registered except the two line outputs, tied low
//
// Function
// - status bit 7 reads data line level
// - status bit 2 reads clock line level
// - control bit 1 low drives data line
// - control bit 0 low drives clock line
// - monitor link active only when select is 0
// - two scratch bytes, reset zero, firmware only
// - four 7-bit multipliers, bit 7 reserved
// - frequency = ref times mul over divider
// - divider bits 5:1, post-scaler bit 0
// - misc clock-select field picks active clock
// - multipliers load documented reset values; dividers come from outside
// - clock-select code 10 is flat panel default
// - bit 7 picks one or two banks
// - bus width field resets to 11
// - bit 6 disables fast-page write detection
// - row cycle length from three timing bits
// - bit 1 selects asymmetric addressing
// - bit 0 selects multiple column strobes
// - coarse x responds at eight aliased indices
// - index bits 7:5 hold fine position
// - coarse x applies after coarse y write
// - bank accessible only with unlock pattern
`timescale 1ns/1ns
`default_nettype none

module seq_ext_config_regs (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // sequencer index/data port
  input  wire logic       idx_wr,
  input  wire logic       idx_rd,
  input  wire logic       data_wr,
  input  wire logic       data_rd,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  // settings held elsewhere in the device
  input  wire logic [7:0] extension_unlock_register,
  input  wire logic       video_port_function_select,
  input  wire logic [1:0] clock_select,
  input  wire logic [7:0] pixel_clock0_divider,
  input  wire logic [7:0] pixel_clock1_divider,
  input  wire logic [7:0] pixel_clock2_divider,
  input  wire logic [7:0] pixel_clock3_divider,
  input  wire logic       row_cycle_extra_bit_a,
  input  wire logic       row_cycle_extra_bit_b,
  // monitor link open-drain pins
  input  wire logic       monitor_link_data_line_in,
  output logic            monitor_link_data_line_out,
  output logic            monitor_link_data_line_oe,
  input  wire logic       monitor_link_clock_line_in,
  output logic            monitor_link_clock_line_out,
  output logic            monitor_link_clock_line_oe,
  // pixel clock synthesizer settings
  output logic      [6:0] video_pixel_clock_multiplier,
  output logic      [4:0] video_pixel_clock_denominator,
  output logic            video_pixel_clock_post_scale,
  // display memory settings
  output logic            mem_two_banks,
  output logic            mem_fast_page_disable,
  output logic      [1:0] mem_bus_width,
  output logic      [3:0] mem_ras_cycle_mclks,
  output logic            mem_asymmetric,
  output logic            mem_multi_cas,
  // cursor/icon horizontal position in effect
  output logic     [10:0] cursor_icon_x
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       index;
    logic [1:0]       ddc_ctl;
    logic             data_lvl;
    logic             clk_lvl;
    logic             data_oe;
    logic             clk_oe;
    logic [7:0]       scratch0;
    logic [7:0]       scratch1;
    logic [3:0][6:0]  mul;
    logic [7:0]       mem_ctl;
    logic [7:0]       coarse_x;
    logic [2:0]       fine_x;
    logic [10:0]      x_active;
    logic [6:0]       sel_mul;
    logic [4:0]       sel_den;
    logic             sel_post;
    logic [3:0]       ras_cyc;
    logic [7:0]       rd_data;
    logic             rd_valid;
  } state_t;

  state_t state_q;
  state_t state_d;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_coarse(input logic [7:0] idx,
                                     input logic [4:0] low);
    is_coarse = (idx[4:0] == low);
  endfunction : is_coarse

  function automatic logic [7:0] pick_div(input logic [1:0] n,
                                          input logic [7:0] d0,
                                          input logic [7:0] d1,
                                          input logic [7:0] d2,
                                          input logic [7:0] d3);
    unique case (n)
      2'h0: pick_div = d0;
      2'h1: pick_div = d1;
      2'h2: pick_div = d2;
      2'h3: pick_div = d3;
    endcase
  endfunction : pick_div

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic       unlocked;
  logic       link_on;
  logic [7:0] div_sel;
  logic [1:0] mul_n;
  logic [2:0] ras_key;

  always_comb begin
    state_d  = state_q;
    // the index port stays open while the bank is locked
    unlocked = ((extension_unlock_register & seq_ext_pkg::UNLOCK_MASK)
                == seq_ext_pkg::UNLOCK_VALUE);
    link_on  = !video_port_function_select;
    // multiplier slot: indices 0b..0e wrap onto slots 0..3
    mul_n    = state_q.index[1:0] - 2'h3;
    div_sel  = pick_div(clock_select, pixel_clock0_divider,
                        pixel_clock1_divider, pixel_clock2_divider,
                        pixel_clock3_divider);
    ras_key  = {row_cycle_extra_bit_a, row_cycle_extra_bit_b,
                state_q.mem_ctl[seq_ext_pkg::MEM_RAS_SEL_BIT]};
    // read strobe is a one-cycle pulse
    state_d.rd_valid = 1'b0;

    // ---------------------------------------------------------------
    // sampled pin levels and line drive enables, zero while the link is switched off
    // ---------------------------------------------------------------
    state_d.data_lvl = link_on & monitor_link_data_line_in;
    state_d.clk_lvl  = link_on & monitor_link_clock_line_in;
    state_d.data_oe  = link_on & !state_q.ddc_ctl[1];
    state_d.clk_oe   = link_on & !state_q.ddc_ctl[0];

    // ---------------------------------------------------------------
    // index port; the stored index also keeps the fine position
    // ---------------------------------------------------------------
    if (idx_wr) begin
      state_d.index = wr_data;
    end
    if (idx_rd) begin
      state_d.rd_data  = state_q.index;
      state_d.rd_valid = 1'b1;
    end

    // ---------------------------------------------------------------
    // data port writes
    // ---------------------------------------------------------------
    if (data_wr && unlocked) begin
      if (state_q.index == seq_ext_pkg::IDX_DDC_CTL_STAT) begin
        state_d.ddc_ctl = wr_data[1:0] & seq_ext_pkg::MASK_DDC_CTL[1:0];
      end
      if (state_q.index == seq_ext_pkg::IDX_SCRATCH_0) begin
        state_d.scratch0 = wr_data;
      end
      if (state_q.index == seq_ext_pkg::IDX_SCRATCH_1) begin
        state_d.scratch1 = wr_data;
      end
      if (state_q.index >= seq_ext_pkg::IDX_PCLK_MUL_0 &&
          state_q.index < seq_ext_pkg::IDX_MEM_CTL) begin
        // only the addressed multiplier changes
        state_d.mul[mul_n] = wr_data[6:0] & seq_ext_pkg::MASK_PCLK[6:0];
      end
      if (state_q.index == seq_ext_pkg::IDX_MEM_CTL) begin
        state_d.mem_ctl = wr_data & seq_ext_pkg::MASK_MEM_CTL;
      end
      if (is_coarse(state_q.index, seq_ext_pkg::IDX_COARSE_X_LO)) begin
        state_d.coarse_x = wr_data;
        state_d.fine_x   = state_q.index[7:5];
      end
      if (is_coarse(state_q.index, seq_ext_pkg::IDX_COARSE_Y_LO)) begin
        // a vertical write commits the pending horizontal position
        state_d.x_active = {state_q.coarse_x, state_q.fine_x};
      end
    end

    // ---------------------------------------------------------------
    // data port reads
    // ---------------------------------------------------------------
    if (data_rd) begin
      state_d.rd_valid = 1'b1;
      // reserved, unmapped and locked reads all return zero
      state_d.rd_data  = 8'h00;
      if (unlocked) begin
        if (state_q.index == seq_ext_pkg::IDX_DDC_CTL_STAT) begin
          state_d.rd_data = {state_q.data_lvl, 4'h0, state_q.clk_lvl,
                             state_q.ddc_ctl};
        end
        if (state_q.index == seq_ext_pkg::IDX_SCRATCH_0) begin
          state_d.rd_data = state_q.scratch0;
        end
        if (state_q.index == seq_ext_pkg::IDX_SCRATCH_1) begin
          state_d.rd_data = state_q.scratch1;
        end
        if (state_q.index >= seq_ext_pkg::IDX_PCLK_MUL_0 &&
            state_q.index < seq_ext_pkg::IDX_MEM_CTL) begin
          state_d.rd_data = {1'b0, state_q.mul[mul_n]};
        end
        if (state_q.index == seq_ext_pkg::IDX_MEM_CTL) begin
          state_d.rd_data = state_q.mem_ctl;
        end
        if (is_coarse(state_q.index, seq_ext_pkg::IDX_COARSE_X_LO)) begin
          state_d.rd_data = state_q.coarse_x;
        end
      end
    end

    // ---------------------------------------------------------------
    // selected synthesizer settings
    // ---------------------------------------------------------------
    // clock-select code 2 is the flat panel default, chosen outside
    state_d.sel_mul  = state_q.mul[clock_select];
    state_d.sel_den  = div_sel[seq_ext_pkg::DIV_DENOM_HI:
                               seq_ext_pkg::DIV_DENOM_LO];
    state_d.sel_post = div_sel[seq_ext_pkg::DIV_POST_BIT];

    // ---------------------------------------------------------------
    // row strobe cycle length
    // ---------------------------------------------------------------
    unique case (ras_key)
      3'b001:  state_d.ras_cyc = seq_ext_pkg::RAS_CYC_SHORT;
      3'b010:  state_d.ras_cyc = seq_ext_pkg::RAS_CYC_LONG;
      3'b110:  state_d.ras_cyc = seq_ext_pkg::RAS_CYC_LONGEST;
      default: state_d.ras_cyc = seq_ext_pkg::RAS_CYC_DEFAULT;
    endcase

    // ---------------------------------------------------------------
    // synchronous reset, last so that it overrides everything above
    // ---------------------------------------------------------------
    if (reset) begin
      state_d          = '0;
      // control bits reset to 0, so both lines are pulled low at once unless the link is switched off
      state_d.data_oe  = link_on;
      state_d.clk_oe   = link_on;
      state_d.ddc_ctl  = seq_ext_pkg::RST_DDC_CTL[1:0];
      state_d.scratch0 = seq_ext_pkg::RST_SCRATCH;
      state_d.scratch1 = seq_ext_pkg::RST_SCRATCH;
      state_d.mul[0]   = seq_ext_pkg::RST_PCLK_MUL_0;
      state_d.mul[1]   = seq_ext_pkg::RST_PCLK_MUL_1;
      state_d.mul[2]   = seq_ext_pkg::RST_PCLK_MUL_2;
      state_d.mul[3]   = seq_ext_pkg::RST_PCLK_MUL_3;
      state_d.mem_ctl  = seq_ext_pkg::RST_MEM_CTL;
      state_d.ras_cyc  = seq_ext_pkg::RAS_CYC_DEFAULT;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    state_q <= state_d;
  end

  // ---------------------------------------------------------------
  // outputs, straight from flip-flops except the two line outputs tied low
  // ---------------------------------------------------------------
  assign rd_data                       = state_q.rd_data;
  assign rd_valid                      = state_q.rd_valid;
  // open drain: the pins only ever pull low, oe is high while driving
  assign monitor_link_data_line_out    = 1'b0;
  assign monitor_link_data_line_oe     = state_q.data_oe;
  assign monitor_link_clock_line_out   = 1'b0;
  assign monitor_link_clock_line_oe    = state_q.clk_oe;
  assign video_pixel_clock_multiplier  = state_q.sel_mul;
  assign video_pixel_clock_denominator = state_q.sel_den;
  assign video_pixel_clock_post_scale  = state_q.sel_post;
  assign mem_two_banks         = state_q.mem_ctl[seq_ext_pkg::MEM_BANK_BIT];
  assign mem_fast_page_disable = state_q.mem_ctl[seq_ext_pkg::MEM_FPD_DIS_BIT];
  assign mem_bus_width         = state_q.mem_ctl[seq_ext_pkg::MEM_WIDTH_HI:
                                                 seq_ext_pkg::MEM_WIDTH_LO];
  assign mem_ras_cycle_mclks   = state_q.ras_cyc;
  assign mem_asymmetric        = state_q.mem_ctl[seq_ext_pkg::MEM_ASYM_BIT];
  assign mem_multi_cas         = state_q.mem_ctl[seq_ext_pkg::MEM_MULTI_CAS_BIT];
  assign cursor_icon_x         = state_q.x_active;

endmodule : seq_ext_config_regs

`default_nettype wire

// [logic/seq_ext_pkg.sv]
// Purpose: constants for the extended sequencer configuration bank
// Assumes: registers reached through the sequencer index/data port pair
// Notes:   indices are the 8-bit sequencer index values; the two coarse ones give index bits 4:0 only
package seq_ext_pkg;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_DDC_CTL_STAT = 8'h08;
  localparam logic [7:0] IDX_SCRATCH_0    = 8'h09;
  localparam logic [7:0] IDX_SCRATCH_1    = 8'h0a;
  localparam logic [7:0] IDX_PCLK_MUL_0   = 8'h0b;
  localparam logic [7:0] IDX_MEM_CTL      = 8'h0f;
  localparam logic [4:0] IDX_COARSE_X_LO  = 5'h10;
  localparam logic [4:0] IDX_COARSE_Y_LO  = 5'h11;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DDC_DATA_STAT_BIT = 7;
  localparam int DDC_CLK_STAT_BIT  = 2;
  localparam int DDC_DATA_CTL_BIT  = 1;
  localparam int DDC_CLK_CTL_BIT   = 0;
  localparam int MEM_BANK_BIT      = 7;
  localparam int MEM_FPD_DIS_BIT   = 6;
  localparam int MEM_WIDTH_HI      = 4;
  localparam int MEM_WIDTH_LO      = 3;
  localparam int MEM_RAS_SEL_BIT   = 2;
  localparam int MEM_ASYM_BIT      = 1;
  localparam int MEM_MULTI_CAS_BIT = 0;
  localparam int DIV_DENOM_HI      = 5;
  localparam int DIV_DENOM_LO      = 1;
  localparam int DIV_POST_BIT      = 0;

  // ---------------------------------------------------------------
  // write masks (reserved bits hold zero)
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_DDC_CTL = 8'h03;
  localparam logic [7:0] MASK_PCLK    = 8'h7f;
  localparam logic [7:0] MASK_MEM_CTL = 8'hdf;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_SCRATCH  = 8'h00;
  localparam logic [7:0] RST_DDC_CTL  = 8'h00;
  localparam logic [7:0] RST_MEM_CTL  = 8'h19;
  localparam logic [6:0] RST_PCLK_MUL_0 = 7'h66;
  localparam logic [6:0] RST_PCLK_MUL_1 = 7'h5b;
  localparam logic [6:0] RST_PCLK_MUL_2 = 7'h45;
  localparam logic [6:0] RST_PCLK_MUL_3 = 7'h7e;
  // companion divider resets, held by the divider bank outside
  localparam logic [7:0] RST_PCLK_DIV_0 = 8'h3b;
  localparam logic [7:0] RST_PCLK_DIV_1 = 8'h2f;
  localparam logic [7:0] RST_PCLK_DIV_2 = 8'h30;
  localparam logic [7:0] RST_PCLK_DIV_3 = 8'h33;
  localparam logic [1:0] FLAT_PANEL_CLK_SEL = 2'h2;

  // ---------------------------------------------------------------
  // row strobe cycle lengths in memory clocks
  // ---------------------------------------------------------------
  localparam logic [3:0] RAS_CYC_DEFAULT = 4'h7;
  localparam logic [3:0] RAS_CYC_SHORT   = 4'h6;
  localparam logic [3:0] RAS_CYC_LONG    = 4'h8;
  localparam logic [3:0] RAS_CYC_LONGEST = 4'h9;

  // ---------------------------------------------------------------
  // unlock pattern, checked on bits 4 and 2:0
  // ---------------------------------------------------------------
  localparam logic [7:0] UNLOCK_MASK  = 8'h17;
  localparam logic [7:0] UNLOCK_VALUE = 8'h12;

endpackage : seq_ext_pkg

// [dv/seq_ext_config_regs_properties.sv]
// Purpose: port-level checks for the extended sequencer bank
// Assumes: one clock, synchronous active-high reset
// Notes:   the stored index is tracked here from index port writes
`timescale 1ns/1ns
`default_nettype none

module seq_ext_config_regs_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // register port
  input wire logic        idx_wr,
  input wire logic        data_wr,
  input wire logic        data_rd,
  input wire logic  [7:0] wr_data,
  input wire logic  [7:0] rd_data,
  input wire logic        rd_valid,
  // settings and link pins
  input wire logic  [7:0] extension_unlock_register,
  input wire logic        video_port_function_select,
  input wire logic        monitor_link_data_line_in,
  input wire logic        monitor_link_data_line_out,
  input wire logic        monitor_link_data_line_oe,
  input wire logic        monitor_link_clock_line_out,
  input wire logic        monitor_link_clock_line_oe,
  // settings in effect
  input wire logic        mem_two_banks,
  input wire logic        mem_fast_page_disable,
  input wire logic  [1:0] mem_bus_width,
  input wire logic [10:0] cursor_icon_x
);
  // ----------
  // index tracking
  // ----------
  logic [7:0] idx_q;
  logic       open_w;
  logic       ddc_w;

  always_ff @(posedge ref_clk) begin
    if (reset)
      idx_q <= 8'h00;
    else if (idx_wr)
      idx_q <= wr_data;
  end

  assign open_w = (extension_unlock_register & seq_ext_pkg::UNLOCK_MASK)
                  == seq_ext_pkg::UNLOCK_VALUE;
  assign ddc_w  = open_w && (idx_q == seq_ext_pkg::IDX_DDC_CTL_STAT);

  // ----------
  // properties
  // ----------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence ddc_write;
    data_wr && ddc_w;
  endsequence
  sequence link_held;
    !data_wr && !video_port_function_select;
  endsequence

  locked_read_zero_a: assert property (data_rd && !open_w |=> rd_valid && rd_data == 8'h00)
    else $error("locked read returned data");
  data_status_a: assert property (data_rd && ddc_w && !video_port_function_select
    && !$past(video_port_function_select) && $stable(monitor_link_data_line_in)
    |=> rd_data[7] == $past(monitor_link_data_line_in))
    else $error("data line status wrong");
  oe_follow_a: assert property (ddc_write ##1 link_held |=>
    {monitor_link_data_line_oe, monitor_link_clock_line_oe} == ~$past(wr_data[1:0], 2))
    else $error("line drive does not follow control");
  link_off_a: assert property ($past(video_port_function_select) |->
    !monitor_link_data_line_oe && !monitor_link_clock_line_oe)
    else $error("line driven while link disabled");
  link_off_read_a: assert property (data_rd && ddc_w && video_port_function_select
    && $past(video_port_function_select) |=> rd_data[7] == 1'b0 && rd_data[2] == 1'b0)
    else $error("status visible while link disabled");
  open_drain_a: assert property (!monitor_link_data_line_out && !monitor_link_clock_line_out)
    else $error("line driven high");
  cursor_hold_a: assert property (!(data_wr && open_w
    && idx_q[4:0] == seq_ext_pkg::IDX_COARSE_Y_LO) |=> $stable(cursor_icon_x))
    else $error("cursor position moved without vertical write");
  mem_hold_a: assert property (!(data_wr && idx_q == seq_ext_pkg::IDX_MEM_CTL) [*2]
    |=> $stable({mem_two_banks, mem_fast_page_disable, mem_bus_width}))
    else $error("memory settings moved without write");
endmodule : seq_ext_config_regs_chk

bind seq_ext_config_regs seq_ext_config_regs_chk u_chk (
  .ref_clk, .reset, .idx_wr, .data_wr, .data_rd, .wr_data, .rd_data, .rd_valid,
  .extension_unlock_register, .video_port_function_select, .monitor_link_data_line_in,
  .monitor_link_data_line_out, .monitor_link_data_line_oe, .monitor_link_clock_line_out,
  .monitor_link_clock_line_oe, .mem_two_banks, .mem_fast_page_disable, .mem_bus_width,
  .cursor_icon_x
);
`default_nettype wire

// [dv/testbench.sv]
// Purpose: directed register-port tests for the extended sequencer bank
// Assumes: inputs change 2 ns after the rising edge
// Notes:   link pins are pulled-up open-drain wires with a peer pulling low
`timescale 1ns/1ns
`default_nettype none

module testbench;
  // ----------
  // connections
  // ----------
  logic        ref_clk, reset, idx_wr, idx_rd, data_wr, data_rd, rd_valid;
  logic  [7:0] wr_data, rd_data, extension_unlock_register;
  logic        video_port_function_select, row_cycle_extra_bit_a, row_cycle_extra_bit_b;
  logic        peer_data_low, peer_clock_low, monitor_link_data_line_oe;
  logic        monitor_link_clock_line_oe, video_pixel_clock_post_scale, mem_two_banks;
  logic        mem_fast_page_disable, mem_asymmetric, mem_multi_cas;
  logic  [1:0] clock_select, mem_bus_width;
  logic  [7:0] div [4];
  logic  [6:0] video_pixel_clock_multiplier;
  logic  [4:0] video_pixel_clock_denominator;
  logic  [3:0] mem_ras_cycle_mclks;
  logic [10:0] cursor_icon_x;
  logic  [6:0] mul_rst [4] = '{7'h66, 7'h5b, 7'h45, 7'h7e};
  logic  [2:0] ras_key [4] = '{3'h0, 3'h1, 3'h2, 3'h6};
  logic  [3:0] ras_len [4] = '{4'h7, 4'h6, 4'h8, 4'h9};
  int          err_total = 0;
  int          num_checks = 0;
  int          cycles = 0;
  wire logic   monitor_link_data_line_in  = ~(monitor_link_data_line_oe | peer_data_low);
  wire logic   monitor_link_clock_line_in = ~(monitor_link_clock_line_oe | peer_clock_low);
  wire logic [1:0] oe_pair = {monitor_link_data_line_oe, monitor_link_clock_line_oe};
  wire logic [5:0] mem_bits = {mem_two_banks, mem_fast_page_disable, mem_bus_width,
                               mem_asymmetric, mem_multi_cas};

  seq_ext_config_regs dut (
    .ref_clk, .reset, .idx_wr, .idx_rd, .data_wr, .data_rd, .wr_data, .rd_data, .rd_valid,
    .extension_unlock_register, .video_port_function_select, .clock_select,
    .pixel_clock0_divider(div[0]), .pixel_clock1_divider(div[1]),
    .pixel_clock2_divider(div[2]), .pixel_clock3_divider(div[3]),
    .row_cycle_extra_bit_a, .row_cycle_extra_bit_b, .monitor_link_data_line_in,
    .monitor_link_data_line_out(), .monitor_link_data_line_oe, .monitor_link_clock_line_in,
    .monitor_link_clock_line_out(), .monitor_link_clock_line_oe, .video_pixel_clock_multiplier,
    .video_pixel_clock_denominator, .video_pixel_clock_post_scale, .mem_two_banks,
    .mem_fast_page_disable, .mem_bus_width, .mem_ras_cycle_mclks, .mem_asymmetric,
    .mem_multi_cas, .cursor_icon_x
  );

  // ----------
  // tasks
  // ----------
  task automatic end_of_test();
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : idle

  // index write, data strobe raised by the caller in the same step
  task automatic put_idx(input logic [7:0] a);
    @(posedge ref_clk) #2;
    idx_wr  = 1'b1;
    wr_data = a;
    @(posedge ref_clk) #2;
    idx_wr  = 1'b0;
  endtask : put_idx

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    put_idx(a);
    data_wr = 1'b1;
    wr_data = v;
    @(posedge ref_clk) #2;
    data_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    put_idx(a);
    data_rd = 1'b1;
    @(posedge ref_clk) #2;
    data_rd = 1'b0;
    chk(rd_valid, 1'b1);
    chk(rd_data, exp);
  endtask : rd

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      end_of_test();
    end
  end

  // ----------
  // sequence
  // ----------
  initial begin
    {reset, idx_wr, idx_rd, data_wr, data_rd} = 5'h10;
    {wr_data, clock_select, video_port_function_select} = 11'h000;
    {row_cycle_extra_bit_a, row_cycle_extra_bit_b, peer_data_low, peer_clock_low} = 4'h0;
    extension_unlock_register = 8'h12;
    div = '{8'h3b, 8'h2f, 8'h30, 8'h33};
    repeat (2) @(posedge ref_clk);
    #2 reset = 1'b0;
    chk(oe_pair, 2'h3);
    rd(8'h08, 8'h00);
    rd(8'h0f, 8'h19);
    chk(mem_bits, 6'h0d);
    chk(mem_ras_cycle_mclks, 4'h7);
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'h0b + i), {1'b0, mul_rst[i]});
      clock_select = 2'(i);
      idle(3);
      chk(video_pixel_clock_multiplier, mul_rst[i]);
      chk({video_pixel_clock_denominator, video_pixel_clock_post_scale}, div[i][5:0]);
    end
    clock_select = 2'h2;
    idle(3);
    chk(video_pixel_clock_multiplier, 7'h45);
    rd(8'h09, 8'h00);
    wr(8'h09, 8'ha5);
    wr(8'h0a, 8'h5a);
    rd(8'h09, 8'ha5);
    rd(8'h0a, 8'h5a);
    rd(8'h07, 8'h00);
    wr(8'h0f, 8'hff);
    rd(8'h0f, 8'hdf);
    chk(mem_bits, 6'h3f);
    wr(8'h0f, 8'h58);
    idle(2);
    chk(mem_bits, 6'h1c);
    for (int i = 0; i < 4; i++) begin
      {row_cycle_extra_bit_a, row_cycle_extra_bit_b} = ras_key[i][2:1];
      wr(8'h0f, {3'h0, 2'h3, ras_key[i][0], 2'h1});
      idle(3);
      chk(mem_ras_cycle_mclks, ras_len[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'h0b + i), 8'(8'hf0 + i));
      rd(8'(8'h0b + i), 8'(8'h70 + i));
      clock_select = 2'(i);
      idle(3);
      chk(video_pixel_clock_multiplier, 7'(7'h70 + i));
    end
    wr(8'h08, 8'h03);
    peer_clock_low = 1'b1;
    rd(8'h08, 8'h83);
    peer_clock_low = 1'b0;
    peer_data_low = 1'b1;
    rd(8'h08, 8'h07);
    peer_data_low = 1'b0;
    wr(8'h08, 8'h02);
    idle(2);
    chk(oe_pair, 2'h1);
    wr(8'h08, 8'h01);
    idle(2);
    chk(oe_pair, 2'h2);
    video_port_function_select = 1'b1;
    idle(2);
    chk(oe_pair, 2'h0);
    rd(8'h08, 8'h01);
    video_port_function_select = 1'b0;
    extension_unlock_register = 8'h13;
    wr(8'h09, 8'h33);
    rd(8'h09, 8'h00);
    extension_unlock_register = 8'hf2;
    rd(8'h09, 8'ha5);
    wr(8'h50, 8'h12);
    idle(2);
    chk(cursor_icon_x, 11'h000);
    wr(8'hf1, 8'h00);
    idle(2);
    chk(cursor_icon_x, 11'h092);
    wr(8'hf0, 8'hab);
    wr(8'h31, 8'h00);
    idle(2);
    chk(cursor_icon_x, 11'h55f);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
